// ===== common/ssd_map.svh
// register offsets, reset values, status bit positions and capture sizes
// assumes byte offsets on an 8-bit register address, one word per register
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH

// register offsets
`define SSD_A_NOMINAL 8'h00
`define SSD_A_SWELL 8'h04
`define SSD_A_SAG 8'h08
`define SSD_A_STEP 8'h0C
`define SSD_A_HYST 8'h10
`define SSD_A_SS_PRIO 8'h14
`define SSD_A_TR_THR 8'h18
`define SSD_A_TR_PRIO 8'h1C
`define SSD_A_CUTOFF 8'h20
`define SSD_A_STATUS 8'h24
`define SSD_A_MASK 8'h28
`define SSD_A_STATE 8'h2C
`define SSD_A_REP_MAG 8'h30
`define SSD_A_REP_DUR 8'h34
`define SSD_A_SUB_CNT 8'h38
`define SSD_A_CTRL 8'h3C

// reset values
`define SSD_R_NOMINAL 16'h0000
`define SSD_R_SWELL 8'h6E
`define SSD_R_SAG 8'h5A
`define SSD_R_STEP 8'h0A
`define SSD_R_HYST 8'h02
`define SSD_R_PRIO 8'h00
`define SSD_R_TR_THR 8'h7D
`define SSD_R_CUTOFF 8'h00
`define SSD_R_CTRL 1'h0

// percent scale factor
`define SSD_PCT_FULL 9'h064

// status bit positions
`define SSD_ST_SAG 0
`define SSD_ST_SWELL 1
`define SSD_ST_END 2
`define SSD_ST_SUB 3
`define SSD_ST_TR 4
`define SSD_ST_SAG_CAP 5
`define SSD_ST_TR_CAP 6
`define SSD_ST_W 7

// capture geometry: input stream runs at the transient rate
`define SSD_IN_SPC 10'h200
`define SSD_SAG_SPC 10'h020
`define SSD_SAG_CYC 10'h036
`define SSD_TR_SPC 10'h200
`define SSD_TR_CYC 10'h004

`endif

// ===== common/ssd_pkg.sv
// types shared by the disturbance detector and its capture engine
// assumes ssd_map.svh provides the numeric constants
package ssd_pkg;

  // disturbance state of the sag/swell tracker
  typedef enum logic [1:0] {SSD_IDLE, SSD_SAG, SSD_SWELL} ssd_dist_t;

  // capture engine state
  typedef enum logic {SSD_CAP_IDLE, SSD_CAP_RUN} ssd_cap_st_t;

endpackage : ssd_pkg

// ===== common/ssd_cap_if.sv
// link between the detector and one waveform capture engine
// assumes both ends share the detector clock
`timescale 1ns/1ps
`default_nettype none

interface ssd_cap_if;
  logic start;
  logic smp_valid;
  logic [15:0] smp_data;
  logic busy;
  logic done;
  logic out_valid;
  logic [15:0] out_data;

  // detector side
  modport ctl (output start, output smp_valid, output smp_data,
    input busy, input done, input out_valid, input out_data);

  // capture engine side
  modport cap (input start, input smp_valid, input smp_data,
    output busy, output done, output out_valid, output out_data);
endinterface : ssd_cap_if

`default_nettype wire

// ===== core/ssd_capture.sv
// one waveform capture engine: decimates the sample stream and emits a
// fixed-length record; assumes samples arrive at the transient rate
`timescale 1ns/1ps
`default_nettype none
`include "ssd_map.svh"

module ssd_capture #(
  parameter logic [9:0] SPC = `SSD_SAG_SPC,
  parameter logic [9:0] CYC = `SSD_SAG_CYC
) (
  input wire logic clk,
  input wire logic reset,
  ssd_cap_if.cap cif
);
  import ssd_pkg::*;

  localparam logic [9:0] DECIM = 10'(`SSD_IN_SPC / SPC);
  localparam logic [19:0] LEN = 20'(SPC) * 20'(CYC);

  ssd_cap_st_t st_ff;
  logic [9:0] dec_ff;
  logic [19:0] n_ff;
  logic take;
  logic last;

  assign take = (st_ff == SSD_CAP_RUN) && cif.smp_valid && (dec_ff == 10'h000);
  assign last = take && (n_ff == LEN - 20'h00001);
  assign cif.busy = (st_ff == SSD_CAP_RUN);

  // run state: a start while running is ignored
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st_ff <= SSD_CAP_IDLE;
    else
      case (st_ff)
        SSD_CAP_IDLE: if (cif.start) st_ff <= SSD_CAP_RUN;
        SSD_CAP_RUN: if (last) st_ff <= SSD_CAP_IDLE;
        default: st_ff <= SSD_CAP_IDLE;
      endcase
  end

  // decimation phase and sample count
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dec_ff <= 10'h000;
      n_ff <= 20'h00000;
    end
    else if (st_ff == SSD_CAP_IDLE)
    begin
      dec_ff <= 10'h000;
      n_ff <= 20'h00000;
    end
    else if (cif.smp_valid)
    begin
      dec_ff <= (dec_ff == DECIM - 10'h001) ? 10'h000 : dec_ff + 10'h001;
      if (take) n_ff <= last ? 20'h00000 : n_ff + 20'h00001; // wrap at end
    end
  end

  // record output and end-of-record pulse
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cif.out_valid <= 1'b0;
      cif.out_data <= 16'h0000;
      cif.done <= 1'b0;
    end
    else
    begin
      cif.out_valid <= take;
      if (take) cif.out_data <= cif.smp_data;
      cif.done <= last;
    end
  end

  AST_CAP_LEN: assert property (@(posedge clk) disable iff (reset)
    n_ff < LEN)
    else $error("capture ran past its record length");
endmodule : ssd_capture

`default_nettype wire

// ===== core/ssd_top.sv
// sag, swell and transient detector with event log gate and two captures
// assumes sample magnitudes come from logic on clk, in volts like nominal
// Summary of operation
// - a sample above swell limit percent of nominal starts a swell.
// - a sample below sag limit percent of nominal starts a sag.
// - inside a disturbance a change of at least the step starts a sub-event.
// - a zero nominal voltage switches every detection off.
// - a sag or swell ends at or past its limit moved by the hysteresis, or when nominal is set to zero.
// - each finished sag or swell reports its extreme magnitude and duration.
// - the sag/swell priority is an 8-bit setting that resets to zero.
// - sag/swell events are logged only if priority exceeds the cutoff.
// - a sample at or above the transient threshold flags a transient.
// - transients are logged only if their priority exceeds the cutoff.
// - a sag captures 54 cycles at 32 samples per cycle.
// - a transient captures 4 cycles at 512 samples per cycle, apart.
// - one nominal setting is the reference of every comparison.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_map.svh"

module ssd_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic smp_valid,
  input wire logic [15:0] smp_mag,
  output logic irq,
  output logic log_req,
  output logic log_kind,
  output logic [7:0] log_prio,
  output logic rep_valid,
  output logic rep_kind,
  output logic [15:0] rep_mag,
  output logic [31:0] rep_dur,
  output logic tr_active,
  output logic sag_cap_valid,
  output logic [15:0] sag_cap_data,
  output logic tr_cap_valid,
  output logic [15:0] tr_cap_data
);
  import ssd_pkg::*;

  // value times percent, kept at full width
  function automatic logic [24:0] ssd_scale(input logic [15:0] v,
                                            input logic [8:0] p);
    ssd_scale = v * p;
  endfunction : ssd_scale

  // distance between two scaled magnitudes
  function automatic logic [24:0] ssd_dist(input logic [24:0] a,
                                           input logic [24:0] b);
    ssd_dist = (a > b) ? a - b : b - a;
  endfunction : ssd_dist

  logic [15:0] nominal_ff;
  logic [7:0] swell_ff, sag_ff, step_ff, hyst_ff, ss_prio_ff;
  logic [7:0] tr_thr_ff, tr_prio_ff, cutoff_ff;
  logic export_en_ff;
  logic [`SSD_ST_W-1:0] status_ff, mask_ff, ev_set, nxt_status;
  ssd_dist_t dist_ff, nxt_dist;
  logic [15:0] ext_ff, ref_ff;
  logic [31:0] dur_ff;
  logic [15:0] sub_ff;
  logic tr_pend_ff;
  logic mon_en, cfg_ok, st_rd;
  logic [24:0] mag100, sag_thr, sag_end, swell_thr, swell_end, tr_thr;
  logic [24:0] step_thr;
  logic ss_start, ss_end, sub_hit, tr_hit, tr_start;
  logic ss_log, tr_log;

  ssd_cap_if sag_cif ();
  ssd_cap_if tr_cif ();

  // thresholds, all against the one nominal setting
  assign mon_en = (nominal_ff != `SSD_R_NOMINAL);
  assign mag100 = ssd_scale(smp_mag, `SSD_PCT_FULL);
  assign sag_thr = ssd_scale(nominal_ff, {1'b0, sag_ff});
  assign swell_thr = ssd_scale(nominal_ff, {1'b0, swell_ff});
  assign sag_end = ssd_scale(nominal_ff, 9'({1'b0, sag_ff} + {1'b0, hyst_ff}));
  assign swell_end = ssd_scale(nominal_ff,
    (swell_ff > hyst_ff) ? {1'b0, swell_ff - hyst_ff} : 9'h000);
  assign step_thr = ssd_scale(nominal_ff, {1'b0, step_ff});
  assign tr_thr = ssd_scale(nominal_ff, {1'b0, tr_thr_ff});

  // settings other than the mask and export enable are accepted only while export is off
  assign cfg_ok = reg_wr && !export_en_ff;
  assign st_rd = reg_rd && (reg_addr == `SSD_A_STATUS);

  // next disturbance state
  always_comb
  begin
    nxt_dist = dist_ff;
    if (!mon_en)
      nxt_dist = SSD_IDLE;
    else if (smp_valid)
      case (dist_ff)
        SSD_IDLE:
          if (mag100 < sag_thr) nxt_dist = SSD_SAG;
          else if (mag100 > swell_thr) nxt_dist = SSD_SWELL;
        SSD_SAG: if (mag100 >= sag_end) nxt_dist = SSD_IDLE;
        SSD_SWELL: if (mag100 <= swell_end) nxt_dist = SSD_IDLE;
        default: nxt_dist = SSD_IDLE;
      endcase
  end

  assign ss_start = (dist_ff == SSD_IDLE) && (nxt_dist != SSD_IDLE);
  assign ss_end = (dist_ff != SSD_IDLE) && (nxt_dist == SSD_IDLE);
  assign sub_hit = (dist_ff != SSD_IDLE) && smp_valid &&
    (nxt_dist == dist_ff) &&
    (ssd_dist(mag100, ssd_scale(ref_ff, `SSD_PCT_FULL)) >= step_thr);
  assign tr_hit = mon_en && smp_valid && (mag100 >= tr_thr);
  assign tr_start = tr_hit && !tr_active;
  assign ss_log = ss_end && (ss_prio_ff != 8'h00) &&
    (ss_prio_ff > cutoff_ff);
  assign tr_log = (tr_start || tr_pend_ff) && (tr_prio_ff != 8'h00) &&
    (tr_prio_ff > cutoff_ff);

  // disturbance state register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      dist_ff <= SSD_IDLE;
    else
      dist_ff <= nxt_dist;
  end

  // extreme magnitude, duration in samples and sub-event tracking
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ext_ff <= 16'h0000;
      ref_ff <= 16'h0000;
      dur_ff <= 32'h00000000;
      sub_ff <= 16'h0000;
    end
    else if (ss_start)
    begin
      ext_ff <= smp_mag;
      ref_ff <= smp_mag;
      dur_ff <= 32'h00000001;
      sub_ff <= 16'h0000;
    end
    else if (smp_valid && (dist_ff != SSD_IDLE) && (nxt_dist == dist_ff))
    begin
      if (dur_ff != 32'hFFFFFFFF) dur_ff <= dur_ff + 32'h00000001;
      if ((dist_ff == SSD_SAG) ? (smp_mag < ext_ff) : (smp_mag > ext_ff))
        ext_ff <= smp_mag;
      if (sub_hit)
      begin
        ref_ff <= smp_mag;
        sub_ff <= sub_ff + 16'h0001;
      end
    end
  end

  // report of a finished sag or swell
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rep_valid <= 1'b0;
      rep_kind <= 1'b0;
      rep_mag <= 16'h0000;
      rep_dur <= 32'h00000000;
    end
    else
    begin
      rep_valid <= ss_end;
      if (ss_end)
      begin
        rep_kind <= (dist_ff == SSD_SWELL);
        rep_mag <= ext_ff;
        rep_dur <= dur_ff;
      end
    end
  end

  // transient level and a transient log held back behind a sag/swell log
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tr_active <= 1'b0;
      tr_pend_ff <= 1'b0;
    end
    else
    begin
      if (!mon_en) tr_active <= 1'b0;
      else if (smp_valid) tr_active <= tr_hit;
      tr_pend_ff <= ss_log && tr_log;
    end
  end

  // event log request, sag/swell first
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      log_req <= 1'b0;
      log_kind <= 1'b0;
      log_prio <= 8'h00;
    end
    else
    begin
      log_req <= ss_log || tr_log;
      if (ss_log)
      begin
        log_kind <= 1'b0;
        log_prio <= ss_prio_ff;
      end
      else if (tr_log)
      begin
        log_kind <= 1'b1;
        log_prio <= tr_prio_ff;
      end
    end
  end

  // feed both capture engines, sag capture only on sags
  assign sag_cif.start = ss_start && (nxt_dist == SSD_SAG);
  assign sag_cif.smp_valid = smp_valid;
  assign sag_cif.smp_data = smp_mag;
  assign tr_cif.start = tr_start;
  assign tr_cif.smp_valid = smp_valid;
  assign tr_cif.smp_data = smp_mag;

  ssd_capture #(.SPC(`SSD_SAG_SPC), .CYC(`SSD_SAG_CYC)) u_sag_cap (
    .clk(clk),
    .reset(reset),
    .cif(sag_cif)
  );

  ssd_capture #(.SPC(`SSD_TR_SPC), .CYC(`SSD_TR_CYC)) u_tr_cap (
    .clk(clk),
    .reset(reset),
    .cif(tr_cif)
  );

  // capture streams registered out
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sag_cap_valid <= 1'b0;
      sag_cap_data <= 16'h0000;
      tr_cap_valid <= 1'b0;
      tr_cap_data <= 16'h0000;
    end
    else
    begin
      sag_cap_valid <= sag_cif.out_valid;
      sag_cap_data <= sag_cif.out_data;
      tr_cap_valid <= tr_cif.out_valid;
      tr_cap_data <= tr_cif.out_data;
    end
  end

  // settings; export enable itself is always writable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      nominal_ff <= `SSD_R_NOMINAL;
      swell_ff <= `SSD_R_SWELL;
      sag_ff <= `SSD_R_SAG;
      step_ff <= `SSD_R_STEP;
      hyst_ff <= `SSD_R_HYST;
      ss_prio_ff <= `SSD_R_PRIO;
      tr_thr_ff <= `SSD_R_TR_THR;
      tr_prio_ff <= `SSD_R_PRIO;
      cutoff_ff <= `SSD_R_CUTOFF;
      mask_ff <= {`SSD_ST_W{1'b0}};
      export_en_ff <= `SSD_R_CTRL;
    end
    else
    begin
      if (reg_wr && reg_addr == `SSD_A_CTRL) export_en_ff <= reg_wdata[0];
      if (reg_wr && reg_addr == `SSD_A_MASK)
        mask_ff <= reg_wdata[`SSD_ST_W-1:0];
      if (cfg_ok)
      begin
        if (reg_addr == `SSD_A_NOMINAL) nominal_ff <= reg_wdata[15:0];
        else if (reg_addr == `SSD_A_SWELL) swell_ff <= reg_wdata[7:0];
        else if (reg_addr == `SSD_A_SAG) sag_ff <= reg_wdata[7:0];
        else if (reg_addr == `SSD_A_STEP) step_ff <= reg_wdata[7:0];
        else if (reg_addr == `SSD_A_HYST) hyst_ff <= reg_wdata[7:0];
        else if (reg_addr == `SSD_A_SS_PRIO) ss_prio_ff <= reg_wdata[7:0];
        else if (reg_addr == `SSD_A_TR_THR) tr_thr_ff <= reg_wdata[7:0];
        else if (reg_addr == `SSD_A_TR_PRIO) tr_prio_ff <= reg_wdata[7:0];
        else if (reg_addr == `SSD_A_CUTOFF) cutoff_ff <= reg_wdata[7:0];
      end
    end
  end

  // sticky status: a new event wins over the read that clears it
  always_comb
  begin
    ev_set = {`SSD_ST_W{1'b0}};
    ev_set[`SSD_ST_SAG] = ss_start && (nxt_dist == SSD_SAG);
    ev_set[`SSD_ST_SWELL] = ss_start && (nxt_dist == SSD_SWELL);
    ev_set[`SSD_ST_END] = ss_end;
    ev_set[`SSD_ST_SUB] = sub_hit;
    ev_set[`SSD_ST_TR] = tr_start;
    ev_set[`SSD_ST_SAG_CAP] = sag_cif.done;
    ev_set[`SSD_ST_TR_CAP] = tr_cif.done;
    nxt_status = (st_rd ? {`SSD_ST_W{1'b0}} : status_ff) | ev_set;
  end

  // status and interrupt
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      status_ff <= {`SSD_ST_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      irq <= |(nxt_status & mask_ff);
    end
  end

  // read data, valid the cycle after the read strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h00000000;
    else if (!reg_rd)
      reg_rdata <= 32'h00000000;
    else if (reg_addr == `SSD_A_NOMINAL) reg_rdata <= {16'h0000, nominal_ff};
    else if (reg_addr == `SSD_A_SWELL) reg_rdata <= {24'h000000, swell_ff};
    else if (reg_addr == `SSD_A_SAG) reg_rdata <= {24'h000000, sag_ff};
    else if (reg_addr == `SSD_A_STEP) reg_rdata <= {24'h000000, step_ff};
    else if (reg_addr == `SSD_A_HYST) reg_rdata <= {24'h000000, hyst_ff};
    else if (reg_addr == `SSD_A_SS_PRIO)
      reg_rdata <= {24'h000000, ss_prio_ff};
    else if (reg_addr == `SSD_A_TR_THR) reg_rdata <= {24'h000000, tr_thr_ff};
    else if (reg_addr == `SSD_A_TR_PRIO)
      reg_rdata <= {24'h000000, tr_prio_ff};
    else if (reg_addr == `SSD_A_CUTOFF) reg_rdata <= {24'h000000, cutoff_ff};
    else if (reg_addr == `SSD_A_STATUS) reg_rdata <= {25'h0000000, status_ff};
    else if (reg_addr == `SSD_A_MASK) reg_rdata <= {25'h0000000, mask_ff};
    else if (reg_addr == `SSD_A_STATE)
      reg_rdata <= {26'h0000000, tr_cif.busy, sag_cif.busy, tr_active,
                    mon_en, dist_ff};
    else if (reg_addr == `SSD_A_REP_MAG) reg_rdata <= {16'h0000, rep_mag};
    else if (reg_addr == `SSD_A_REP_DUR) reg_rdata <= rep_dur;
    else if (reg_addr == `SSD_A_SUB_CNT) reg_rdata <= {16'h0000, sub_ff};
    else if (reg_addr == `SSD_A_CTRL)
      reg_rdata <= {31'h00000000, export_en_ff};
    else
      reg_rdata <= 32'h00000000;
  end

  default clocking ssd_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_SWELL_START: assert property (smp_valid && mon_en &&
    dist_ff == SSD_IDLE && mag100 > swell_thr && !(mag100 < sag_thr)
    |=> dist_ff == SSD_SWELL)
    else $error("swell not entered above the swell limit");

  AST_SAG_START: assert property (smp_valid && mon_en &&
    dist_ff == SSD_IDLE && mag100 < sag_thr |=> dist_ff == SSD_SAG)
    else $error("sag not entered below the sag limit");

  AST_SUB_COUNT: assert property (sub_hit |=>
    sub_ff == $past(sub_ff) + 16'h0001 && ref_ff == $past(smp_mag))
    else $error("sub-event step not counted");

  AST_NOM_ZERO: assert property (nominal_ff == 16'h0000 &&
    $past(nominal_ff) == 16'h0000 && $past(nominal_ff, 2) == 16'h0000 &&
    $past(nominal_ff, 3) == 16'h0000
    |-> dist_ff == SSD_IDLE && !tr_active && !log_req)
    else $error("detection active with zero nominal");

  AST_SAG_HYST: assert property (dist_ff == SSD_SAG && mon_en &&
    smp_valid && mag100 >= sag_thr && mag100 < sag_end
    |=> dist_ff == SSD_SAG)
    else $error("sag ended inside the hysteresis band");

  AST_REPORT: assert property (ss_end |=> rep_valid &&
    rep_dur == $past(dur_ff) && rep_mag == $past(ext_ff))
    else $error("disturbance report missing or wrong");

  AST_LOG_GATE: assert property (log_req |-> log_prio != 8'h00 &&
    log_prio > $past(cutoff_ff))
    else $error("event logged at or below the cutoff");

  AST_TR_FLAG: assert property (tr_hit |=> tr_active &&
    ($past(tr_active) || status_ff[`SSD_ST_TR]))
    else $error("transient not flagged at threshold");

  AST_TR_LOG: assert property (tr_start && tr_prio_ff > cutoff_ff &&
    tr_prio_ff != 8'h00 && !ss_log |=> log_req && log_kind)
    else $error("transient log request missing");

  AST_CFG_LOCK: assert property (export_en_ff && reg_wr &&
    reg_addr == `SSD_A_NOMINAL |=> $stable(nominal_ff))
    else $error("setting changed while export enabled");

  AST_STICKY: assert property (st_rd && tr_start |=>
    status_ff[`SSD_ST_TR])
    else $error("event lost during status read");
endmodule : ssd_top

`default_nettype wire

// ===== verif/ssd_smp_src.sv
// sample source standing in for the metering front end
// assumes the bench calls send only after reset has been released
`timescale 1ns/1ps
`default_nettype none

module ssd_smp_src (
  input wire logic clk,
  output logic smp_valid,
  output logic [15:0] smp_mag
);
  // quiet line at time zero
  initial
  begin
    smp_valid = 1'b0;
    smp_mag = 16'h0000;
  end

  // n back-to-back samples; a released line shows junk, not the last value
  task automatic send(input logic [15:0] m, input int n);
    repeat (n)
    begin
      @(posedge clk);
      smp_valid <= 1'b1;
      smp_mag <= m;
    end
    @(posedge clk);
    smp_valid <= 1'b0;
    smp_mag <= ~m;
  endtask : send
endmodule : ssd_smp_src

`default_nettype wire

// ===== verif/ssd_top_bench.sv
// self-checking bench for the sag, swell and transient detector
// assumes ssd_smp_src feeds samples and the bench owns the register port
`timescale 1ns/1ps
`default_nettype none
`include "ssd_map.svh"

module ssd_top_bench;
  logic clk, reset, reg_wr, reg_rd, smp_valid, irq, log_req, log_kind;
  logic rep_valid, rep_kind, tr_active, sag_cap_valid, tr_cap_valid;
  logic [7:0] reg_addr, log_prio;
  logic [31:0] reg_wdata, reg_rdata, rep_dur;
  logic [15:0] smp_mag, rep_mag, sag_cap_data, tr_cap_data;
  int error_cnt, checks, rep_n, log_n, scap_n, tcap_n;

  ssd_top i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .smp_valid(smp_valid), .smp_mag(smp_mag),
    .irq(irq), .log_req(log_req), .log_kind(log_kind), .log_prio(log_prio),
    .rep_valid(rep_valid), .rep_kind(rep_kind), .rep_mag(rep_mag),
    .rep_dur(rep_dur), .tr_active(tr_active),
    .sag_cap_valid(sag_cap_valid), .sag_cap_data(sag_cap_data),
    .tr_cap_valid(tr_cap_valid), .tr_cap_data(tr_cap_data));

  ssd_smp_src i_src (.clk(clk), .smp_valid(smp_valid), .smp_mag(smp_mag));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // count one-cycle pulses of reports, log requests and capture streams
  always @(posedge clk)
  begin
    if (rep_valid === 1'b1) rep_n <= rep_n + 1;
    if (log_req === 1'b1) log_n <= log_n + 1;
    if (sag_cap_valid === 1'b1) scap_n <= scap_n + 1;
    if (tr_cap_valid === 1'b1) tcap_n <= tcap_n + 1;
  end

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input string what, input logic [7:0] a,
    input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic t_defaults;
    rdchk("swell", `SSD_A_SWELL, 32'h6E);
    rdchk("sag", `SSD_A_SAG, 32'h5A);
    rdchk("step", `SSD_A_STEP, 32'h0A);
    rdchk("nominal", `SSD_A_NOMINAL, 32'h0);
    rdchk("hyst", `SSD_A_HYST, 32'h02);
    rdchk("ss_prio", `SSD_A_SS_PRIO, 32'h0);
    rdchk("cutoff", `SSD_A_CUTOFF, 32'h0);
    rdchk("tr_thr", `SSD_A_TR_THR, 32'h7D);
    rdchk("tr_prio", `SSD_A_TR_PRIO, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    idle(1);
    chk("rdata_idle", reg_rdata, 32'h0);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_disabled;
    wr(`SSD_A_MASK, 32'h7F);
    i_src.send(16'h000A, 2);
    i_src.send(16'h00C8, 2);
    idle(3);
    chk("irq", irq, 1'b0);
    chk("tr_active", tr_active, 1'b0);
    chk("rep_n", rep_n, 32'h0);
    rdchk("status", `SSD_A_STATUS, 32'h0);
    $display("test disabled done");
  endtask : t_disabled

  task automatic t_sag;
    wr(`SSD_A_NOMINAL, 32'h64);
    wr(`SSD_A_SS_PRIO, 32'hC8);
    wr(`SSD_A_CUTOFF, 32'h05);
    i_src.send(16'h0055, 3);
    idle(3);
    chk("irq", irq, 1'b1);
    rdchk("status", `SSD_A_STATUS, 32'h01);
    i_src.send(16'h005B, 1);
    idle(3);
    chk("rep_n", rep_n, 32'h0);
    i_src.send(16'h005C, 1);
    idle(3);
    chk("rep_n", rep_n, 32'h1);
    chk("rep_kind", rep_kind, 1'b0);
    chk("rep_mag", rep_mag, 16'h0055);
    chk("rep_dur", rep_dur, 32'h4);
    chk("log_n", log_n, 32'h1);
    chk("log_kind", log_kind, 1'b0);
    chk("log_prio", log_prio, 8'hC8);
    rdchk("status", `SSD_A_STATUS, 32'h04);
    $display("test sag done");
  endtask : t_sag

  task automatic t_swell;
    wr(`SSD_A_SS_PRIO, 32'h0);
    i_src.send(16'h006F, 1);
    i_src.send(16'h0079, 1);
    i_src.send(16'h006D, 1);
    i_src.send(16'h006C, 1);
    idle(3);
    chk("rep_n", rep_n, 32'h2);
    chk("rep_kind", rep_kind, 1'b1);
    chk("rep_mag", rep_mag, 16'h0079);
    chk("rep_dur", rep_dur, 32'h3);
    chk("log_n", log_n, 32'h1);
    rdchk("status", `SSD_A_STATUS, 32'h0E);
    rdchk("sub_cnt", `SSD_A_SUB_CNT, 32'h2);
    rdchk("rep_dur_reg", `SSD_A_REP_DUR, 32'h3);
    $display("test swell done");
  endtask : t_swell

  task automatic t_transient;
    wr(`SSD_A_SWELL, 32'hC8);
    wr(`SSD_A_TR_PRIO, 32'hC8);
    i_src.send(16'h007C, 1);
    idle(2);
    chk("tr_active", tr_active, 1'b0);
    i_src.send(16'h007D, 1);
    idle(3);
    chk("tr_active", tr_active, 1'b1);
    chk("log_n", log_n, 32'h2);
    chk("log_kind", log_kind, 1'b1);
    chk("log_prio", log_prio, 8'hC8);
    i_src.send(16'h0064, 2100);
    idle(4);
    chk("tcap_n", tcap_n, 32'd2048);
    chk("tr_cap_data", tr_cap_data, 16'h0064);
    // sag engine still runs from the earlier sag: every 16th of 2110 samples
    chk("scap_n", scap_n, 32'd132);
    rdchk("status", `SSD_A_STATUS, 32'h50);
    wr(`SSD_A_TR_PRIO, 32'h05);
    i_src.send(16'h007D, 1);
    idle(3);
    chk("log_n", log_n, 32'h2);
    $display("test transient done");
  endtask : t_transient

  task automatic t_sag_capture;
    wr(`SSD_A_MASK, 32'h0);
    rdchk("status", `SSD_A_STATUS, 32'h10);
    i_src.send(16'h0032, 27700);
    idle(4);
    chk("irq", irq, 1'b0);
    chk("scap_n", scap_n, 32'd1728);
    chk("sag_cap_data", sag_cap_data, 16'h0032);
    wr(`SSD_A_MASK, 32'h7F);
    idle(1);
    chk("irq", irq, 1'b1);
    rdchk("status", `SSD_A_STATUS, 32'h61);
    i_src.send(16'h005F, 1);
    idle(3);
    $display("test sag capture done");
  endtask : t_sag_capture

  task automatic t_config;
    wr(`SSD_A_CTRL, 32'h1);
    wr(`SSD_A_NOMINAL, 32'h0);
    rdchk("nominal", `SSD_A_NOMINAL, 32'h64);
    wr(`SSD_A_CTRL, 32'h0);
    wr(`SSD_A_NOMINAL, 32'hC8);
    i_src.send(16'h00E6, 1);
    idle(2);
    chk("tr_active", tr_active, 1'b0);
    // status read in the same cycle as the transient: the new bit survives
    fork
      i_src.send(16'h00FA, 1);
      rdchk("status", `SSD_A_STATUS, 32'h04);
    join
    idle(2);
    chk("tr_active", tr_active, 1'b1);
    rdchk("status", `SSD_A_STATUS, 32'h10);
    rdchk("state", `SSD_A_STATE, 32'h2C);
    $display("test config done");
  endtask : t_config

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // reset, then the scenarios in order
  initial
  begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    {error_cnt, checks, rep_n, log_n, scap_n, tcap_n} = '0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_defaults();
    t_disabled();
    t_sag();
    t_swell();
    t_transient();
    t_sag_capture();
    t_config();
    report_and_stop();
  end

  // the whole run needs about 30000 cycles
  initial
  begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : ssd_top_bench

`default_nettype wire
